//--- design/filter_zone_pkg.sv
// Purpose: constants and types for the sample filter and zone detector
// Assumes: 12-bit samples, 7 converted inputs, plain register port
// Notes: inputs 4..6 (aux, single diode, ratio diode) carry zone logic
// Behaviour
// - filter first, then zone detection stage
// - median, average, combined or bypass modes
// - median codes select 1, 3, 7, 15
// - median 1: window codes 1, 4, 8, 16
// - median above 1: windows 1, 3, 7
// - both sizes 1: sample passes unchanged
// - median 1: average W collected samples
// - window 1: middle of M sorted samples
// - combined: middle W averaged, median twice
// - invalid combination acts as median only
// - filter serves every analog input
// - zone screens results, alerts on condition
// - zones: at or above high, between, at or below low
// - per-input thresholds and zone enables
// - no zone check on touch inputs
// - met zone: irq low, flag set
// - result lands in its input's register
// - samples are 10 or 12 bits
`default_nettype none
package filter_zone_pkg;
  localparam int DATA_W = 12;
  localparam int ADDR_W = 8;
  localparam int BUS_W = 16;
  localparam int NUM_CH = 7;
  localparam int NUM_ZONE = 3;
  localparam int MAX_N = 16;
  localparam logic [2:0] ZONE_BASE_CH = 3'h4;
  ////////////////////////////////////////////////////////////////////////////
  localparam logic [7:0] CFG_OFS = 8'h00;
  localparam logic [7:0] ZONE_OFS = 8'h04;
  localparam logic [7:0] STAT_OFS = 8'h08;
  localparam logic [7:0] THR_BASE = 8'h10;
  localparam logic [7:0] RES_BASE = 8'h40;
  localparam int CFG_MED_LSB = 0;
  localparam int CFG_WIN_LSB = 2;
  localparam int CFG_RES_BIT = 4;
  localparam int ZONE_SEL_LSB = 4;
  localparam logic [15:0] CFG_RST = 16'h0010;
  localparam logic [15:0] ZONE_RST = 16'h0000;
  localparam logic [11:0] THR_LO_RST = 12'h000;
  localparam logic [11:0] THR_HI_RST = 12'hfff;
  localparam logic [11:0] RES10_MASK = 12'h3ff;
  ////////////////////////////////////////////////////////////////////////////
  typedef enum logic [1:0] {ZONE_ABOVE, ZONE_BETWEEN, ZONE_BELOW, ZONE_NONE} zone_e;
  typedef enum logic {ST_COLLECT, ST_EMIT} filt_state_e;
  typedef struct packed {
    logic [2:0] ch;
    logic [11:0] data;
  } sample_s;
  typedef struct packed {
    logic res12;
    logic [1:0] win;
    logic [1:0] med;
  } cfg_s;
  typedef struct packed {
    logic [4:0] n;
    logic [3:0] lo;
    logic [3:0] hi;
    logic [3:0] mid;
    logic dbl;
    logic [2:0] sh;
  } plan_s;
endpackage : filter_zone_pkg
`default_nettype wire

//--- design/sample_preprocess_filter_zone.sv
// Purpose: combined median/averaging filter with zone detection and results
// Assumes: sequencer sends a whole group of one input back to back
// Notes: a change of input mid-group restarts collection with the new sample
`timescale 1ns/1ps
`default_nettype none
module sample_preprocess_filter_zone (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_sample_valid,
  input wire filter_zone_pkg::sample_s i_sample,
  output logic o_sample_ready,
  input wire logic [7:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [15:0] o_rdata,
  output logic o_filt_valid,
  output filter_zone_pkg::sample_s o_filt,
  output logic o_touch_or_result_irq_pin_n
);

  ////////////////////////////////////////////////////////////////////////////
  // size decode
  function automatic filter_zone_pkg::plan_s plan_of(input filter_zone_pkg::cfg_s c);
    logic [1:0] w;
    logic [3:0] half;
    filter_zone_pkg::plan_s p;
    // reserved or oversized windows fall back to median only
    w = ((c.med != 2'h0) && (c.win >= c.med)) ? 2'h0 : c.win;
    half = 4'((4'h1 << w) - 4'h1);
    p.mid = 4'((4'h1 << c.med) - 4'h1);
    p.dbl = (c.med != 2'h0) && (w != 2'h0);
    p.sh = (w == 2'h0) ? 3'h0 : 3'({1'b0, w} + 3'h1);
    if (c.med == 2'h0)
    begin
      p.n = (w == 2'h0) ? 5'h1 : 5'(5'h1 << ({1'b0, w} + 3'h1));
      p.lo = 4'h0;
      p.hi = 4'(p.n - 5'h1);
    end
    else
    begin
      p.n = 5'((5'h1 << ({1'b0, c.med} + 3'h1)) - 5'h1);
      p.lo = 4'(p.mid - half);
      p.hi = 4'(p.mid + half);
    end
    return p;
  endfunction : plan_of

  ////////////////////////////////////////////////////////////////////////////
  // filter state
  filter_zone_pkg::filt_state_e state_q, state_d;
  logic [4:0] cnt_q, cnt_d;
  logic [2:0] gch_q, gch_d;
  logic [11:0] sorted_q [filter_zone_pkg::MAX_N];
  logic [11:0] sorted_d [filter_zone_pkg::MAX_N];
  logic filt_valid_q, filt_valid_d;
  filter_zone_pkg::sample_s filt_q, filt_d;
  filter_zone_pkg::cfg_s cfg_q, cfg_d;
  filter_zone_pkg::plan_s plan;
  logic accept;
  logic [11:0] v;
  logic [4:0] pos;
  logic [15:0] sum;
  logic [11:0] result;

  assign plan = plan_of(cfg_q);
  assign o_sample_ready = (state_q == filter_zone_pkg::ST_COLLECT);
  assign accept = i_sample_valid && o_sample_ready;
  // 10-bit results sit in the low bits so thresholds compare alike
  assign v = cfg_q.res12 ? i_sample.data
             : (i_sample.data & filter_zone_pkg::RES10_MASK);

  // insertion keeps the array sorted, so no separate sort pass is needed
  always_comb
  begin
    state_d = state_q;
    cnt_d = cnt_q;
    gch_d = gch_q;
    filt_valid_d = 1'b0;
    filt_d = filt_q;
    pos = 5'h0;
    sum = 16'h0;
    result = 12'h0;
    sorted_d = sorted_q;
    if (accept)
    begin
      if ((cnt_q == 5'h0) || (i_sample.ch != gch_q))
      begin
        sorted_d[0] = v;
        cnt_d = 5'h1;
      end
      else
      begin
        for (int i = 0; i < filter_zone_pkg::MAX_N; i++)
        begin
          if ((5'(i) < cnt_q) && (sorted_q[i] <= v))
          begin
            pos = 5'(pos + 5'h1);
          end
        end
        for (int i = 0; i < filter_zone_pkg::MAX_N; i++)
        begin
          if (5'(i) < pos)
          begin
            sorted_d[i] = sorted_q[i];
          end
          else if ((5'(i) == pos) || (i == 0))
          begin
            sorted_d[i] = v;
          end
          else
          begin
            sorted_d[i] = sorted_q[i-1];
          end
        end
        cnt_d = 5'(cnt_q + 5'h1);
      end
      gch_d = i_sample.ch;
      if (cnt_d >= plan.n)
      begin
        state_d = filter_zone_pkg::ST_EMIT;
      end
    end
    if (state_q == filter_zone_pkg::ST_EMIT)
    begin
      for (int i = 0; i < filter_zone_pkg::MAX_N; i++)
      begin
        if ((4'(i) >= plan.lo) && (4'(i) <= plan.hi))
        begin
          sum = 16'(sum + {4'h0, sorted_q[i]});
        end
      end
      if (plan.dbl)
      begin
        sum = 16'(sum + {4'h0, sorted_q[plan.mid]});
      end
      result = 12'(sum >> plan.sh);
      filt_d.data = result;
      filt_d.ch = gch_q;
      filt_valid_d = 1'b1;
      cnt_d = 5'h0;
      state_d = filter_zone_pkg::ST_COLLECT;
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      state_q <= filter_zone_pkg::ST_COLLECT;
      cnt_q <= 5'h0;
      gch_q <= 3'h0;
      filt_valid_q <= 1'b0;
      filt_q <= '0;
      for (int i = 0; i < filter_zone_pkg::MAX_N; i++)
      begin
        sorted_q[i] <= 12'h000;
      end
    end
    else
    begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      gch_q <= gch_d;
      filt_valid_q <= filt_valid_d;
      filt_q <= filt_d;
      sorted_q <= sorted_d;
    end
  end

  assign o_filt_valid = filt_valid_q;
  assign o_filt = filt_q;

  ////////////////////////////////////////////////////////////////////////////
  // zone detection and registers
  logic [15:0] zone_q, zone_d;
  logic [11:0] thr_lo_q [filter_zone_pkg::NUM_ZONE];
  logic [11:0] thr_lo_d [filter_zone_pkg::NUM_ZONE];
  logic [11:0] thr_hi_q [filter_zone_pkg::NUM_ZONE];
  logic [11:0] thr_hi_d [filter_zone_pkg::NUM_ZONE];
  logic [11:0] res_q [filter_zone_pkg::NUM_CH];
  logic [11:0] res_d [filter_zone_pkg::NUM_CH];
  logic [6:0] flag_q, flag_d;
  logic [15:0] rdata_q, rdata_d;
  logic is_zoned;
  logic [1:0] zi;
  logic zone_en;
  filter_zone_pkg::zone_e zsel;
  logic zone_met;
  logic keep;

  always_comb
  begin
    is_zoned = (filt_d.ch >= filter_zone_pkg::ZONE_BASE_CH)
               && (filt_d.ch < 3'(filter_zone_pkg::NUM_CH));
    zi = 2'(filt_d.ch - filter_zone_pkg::ZONE_BASE_CH);
    zone_en = is_zoned && zone_q[zi];
    zsel = filter_zone_pkg::zone_e'(zone_q[filter_zone_pkg::ZONE_SEL_LSB + 2*zi +: 2]);
    zone_met = 1'b0;
    if (is_zoned)
    begin
      unique case (zsel)
        filter_zone_pkg::ZONE_ABOVE: zone_met = (filt_d.data >= thr_hi_q[zi]);
        filter_zone_pkg::ZONE_BETWEEN: zone_met = (filt_d.data > thr_lo_q[zi])
                                                  && (filt_d.data < thr_hi_q[zi]);
        filter_zone_pkg::ZONE_BELOW: zone_met = (filt_d.data <= thr_lo_q[zi]);
        filter_zone_pkg::ZONE_NONE: zone_met = 1'b0;
      endcase
    end
    // screened inputs keep only results that meet the zone
    // channel code 7 has no register, so it is never stored
    keep = filt_valid_d && (filt_d.ch < 3'(filter_zone_pkg::NUM_CH))
           && (!zone_en || zone_met);
  end

  always_comb
  begin
    cfg_d = cfg_q;
    zone_d = zone_q;
    flag_d = flag_q;
    rdata_d = 16'h0000;
    thr_lo_d = thr_lo_q;
    thr_hi_d = thr_hi_q;
    res_d = res_q;
    if (i_wr)
    begin
      if (i_addr == filter_zone_pkg::CFG_OFS)
      begin
        cfg_d.med = i_wdata[filter_zone_pkg::CFG_MED_LSB +: 2];
        cfg_d.win = i_wdata[filter_zone_pkg::CFG_WIN_LSB +: 2];
        cfg_d.res12 = i_wdata[filter_zone_pkg::CFG_RES_BIT];
      end
      if (i_addr == filter_zone_pkg::ZONE_OFS)
      begin
        zone_d = {6'h00, i_wdata[9:0]};
      end
      if (i_addr == filter_zone_pkg::STAT_OFS)
      begin
        flag_d = flag_q & ~i_wdata[6:0];
      end
      for (int z = 0; z < filter_zone_pkg::NUM_ZONE; z++)
      begin
        if (i_addr == 8'(filter_zone_pkg::THR_BASE + 8*z))
        begin
          thr_lo_d[z] = i_wdata[11:0];
        end
        if (i_addr == 8'(filter_zone_pkg::THR_BASE + 8*z + 4))
        begin
          thr_hi_d[z] = i_wdata[11:0];
        end
      end
    end
    if (keep)
    begin
      res_d[filt_d.ch] = filt_d.data;
      flag_d[filt_d.ch] = 1'b1;
    end
    if (i_rd)
    begin
      if (i_addr == filter_zone_pkg::CFG_OFS)
      begin
        rdata_d = {11'h000, cfg_q};
      end
      if (i_addr == filter_zone_pkg::ZONE_OFS)
      begin
        rdata_d = zone_q;
      end
      if (i_addr == filter_zone_pkg::STAT_OFS)
      begin
        rdata_d = {9'h000, flag_q};
      end
      for (int z = 0; z < filter_zone_pkg::NUM_ZONE; z++)
      begin
        if (i_addr == 8'(filter_zone_pkg::THR_BASE + 8*z))
        begin
          rdata_d = {4'h0, thr_lo_q[z]};
        end
        if (i_addr == 8'(filter_zone_pkg::THR_BASE + 8*z + 4))
        begin
          rdata_d = {4'h0, thr_hi_q[z]};
        end
      end
      for (int c = 0; c < filter_zone_pkg::NUM_CH; c++)
      begin
        if (i_addr == 8'(filter_zone_pkg::RES_BASE + 4*c))
        begin
          rdata_d = {4'h0, res_q[c]};
        end
      end
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      cfg_q <= filter_zone_pkg::CFG_RST[4:0];
      zone_q <= filter_zone_pkg::ZONE_RST;
      flag_q <= 7'h00;
      rdata_q <= 16'h0000;
      for (int z = 0; z < filter_zone_pkg::NUM_ZONE; z++)
      begin
        thr_lo_q[z] <= filter_zone_pkg::THR_LO_RST;
        thr_hi_q[z] <= filter_zone_pkg::THR_HI_RST;
      end
      for (int c = 0; c < filter_zone_pkg::NUM_CH; c++)
      begin
        res_q[c] <= 12'h000;
      end
    end
    else
    begin
      cfg_q <= cfg_d;
      zone_q <= zone_d;
      flag_q <= flag_d;
      rdata_q <= rdata_d;
      thr_lo_q <= thr_lo_d;
      thr_hi_q <= thr_hi_d;
      res_q <= res_d;
    end
  end

  assign o_rdata = rdata_q;
  assign o_touch_or_result_irq_pin_n = ~(|flag_q);

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);

  sequence bypass_take_s;
    accept && (cnt_q == 5'h0) && (cfg_q.med == 2'h0) && (cfg_q.win == 2'h0);
  endsequence
  sequence touch_out_s;
    filt_valid_d && (filt_d.ch < filter_zone_pkg::ZONE_BASE_CH);
  endsequence

  emit_restart_a: assert property ((state_q == filter_zone_pkg::ST_EMIT) |=>
    (cnt_q == 5'h0) && o_sample_ready && o_filt_valid)
    else $error("group did not restart after output");
  bypass_pass_a: assert property (bypass_take_s ##1 (cfg_q.med == 2'h0) |=>
    o_filt_valid && (o_filt.data == $past(v, 2)))
    else $error("bypass changed the sample");
  count_bound_a: assert property (cnt_q <= plan.n)
    else $error("group count past its size");
  sorted_order_a: assert property ((state_q == filter_zone_pkg::ST_EMIT) |->
    (sorted_q[0] <= sorted_q[plan.hi]) && (sorted_q[plan.lo] <= sorted_q[plan.mid]))
    else $error("collected samples not in order");
  invalid_cfg_a: assert property ((cfg_q.med != 2'h0) && (cfg_q.win >= cfg_q.med)
    |-> (plan.sh == 3'h0) && (plan.lo == plan.hi))
    else $error("invalid setting not median only");
  res10_range_a: assert property ((o_filt_valid && !$past(cfg_q.res12, 2)) |->
    (o_filt.data <= filter_zone_pkg::RES10_MASK))
    else $error("10-bit result exceeds range");
  touch_store_a: assert property (touch_out_s |=>
    (res_q[$past(filt_d.ch)] == $past(filt_d.data)) && flag_q[$past(filt_d.ch)])
    else $error("touch result not stored");
  zone_irq_a: assert property ((filt_valid_d && zone_en && zone_met) |=>
    !o_touch_or_result_irq_pin_n && flag_q[$past(filt_d.ch)])
    else $error("zone hit did not raise alert");
  zone_screen_a: assert property (filt_valid_d && zone_en && !zone_met
    && !flag_q[filt_d.ch] && !i_wr |=> !flag_q[$past(filt_d.ch)])
    else $error("screened result raised flag");

endmodule : sample_preprocess_filter_zone
`default_nettype wire

//--- testbench/sample_sequencer.sv
// Purpose: model of the conversion sequencer that feeds samples
// Assumes: valid/ready beat taken on the rising edge with both high
// Notes: released data shows the inverse of the last beat
`timescale 1ns/1ps
`default_nettype none
module sample_sequencer (
  input wire logic i_sys_clk,
  input wire logic i_ready,
  output logic o_valid,
  output filter_zone_pkg::sample_s o_sample
);
  logic rdy;
  initial
  begin
    o_valid = 1'b0;
    o_sample = '0;
  end
  // ready sampled at the negedge: it is stable until the next rising edge
  task automatic send(input logic [2:0] ch, input logic [11:0] d);
    begin
      o_valid <= 1'b1;
      o_sample <= {ch, d};
      do
      begin
        @(negedge i_sys_clk);
        rdy = i_ready;
        @(posedge i_sys_clk);
      end while (!rdy);
    end
  endtask : send
  // inverted data so a stale beat never passes for a fresh one
  task automatic idle();
    begin
      o_valid <= 1'b0;
      o_sample.data <= ~o_sample.data;
    end
  endtask : idle
endmodule : sample_sequencer
`default_nettype wire

//--- testbench/tb_sample_preprocess_filter_zone.sv
// Purpose: self-checking bench for the filter and zone block
// Assumes: sequencer model feeds samples, bench is the register master
// Notes: sorted values are base+4k*k, so every mode gives its own result
`timescale 1ns/1ps
`default_nettype none
module tb_sample_preprocess_filter_zone;
  typedef struct {logic [4:0] cfg; logic [2:0] ch; int n; logic [11:0] base;
    logic [11:0] exp;} row_s;
  typedef struct {logic [2:0] ch; logic [11:0] v; logic met;} zrow_s;
  logic clk, rst, vld, rdy, wr, rd, fvld, irq_n;
  filter_zone_pkg::sample_s smp, filt;
  logic [7:0] addr;
  logic [15:0] wdata, rdata, got;
  int num_errors = 0, n_compared = 0, cyc = 0, n_out = 0, base_out;
  row_s rows [13];
  zrow_s zr [10];
  sample_preprocess_filter_zone DUT (.i_sys_clk(clk), .i_rst(rst), .i_sample_valid(vld),
    .i_sample(smp), .o_sample_ready(rdy), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
    .i_rd(rd), .o_rdata(rdata), .o_filt_valid(fvld), .o_filt(filt),
    .o_touch_or_result_irq_pin_n(irq_n));
  sample_sequencer src (.i_sys_clk(clk), .i_ready(rdy), .o_valid(vld), .o_sample(smp));
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // run takes a few hundred cycles; the ceiling of 30000 leaves wide margin
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (fvld === 1'b1)
      n_out <= n_out + 1;
    if (cyc == 30000)
    begin
      num_errors++;
      wrap_up();
    end
  end
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    begin
      n_compared++;
      if (seen !== exp)
      begin
        num_errors++;
        $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
    end
  endtask : check
  task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d);
    begin
      wr <= w;
      rd <= !w;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
      rd <= 1'b0;
      @(negedge clk);
      got = rdata;
      @(posedge clk);
    end
  endtask : bus
  task automatic rdchk(input string name, input logic [7:0] a, input logic [15:0] exp);
    begin
      bus(1'b0, a, 16'h0000);
      check(name, got, exp);
    end
  endtask : rdchk
  task automatic group(input logic [2:0] ch, input int n, input logic [11:0] base);
    int k;
    begin
      for (int i = 0; i < n; i++)
      begin
        k = (i * 11 + 3) % n;
        src.send(ch, base + 12'(4 * k * k));
      end
      src.idle();
    end
  endtask : group
  task automatic result(output filter_zone_pkg::sample_s r);
    int t;
    begin
      t = 0;
      while (fvld !== 1'b1 && t < 40)
      begin
        @(negedge clk);
        t++;
      end
      r = filt;
      check("result wait", {15'h0, fvld}, 16'h0001);
      @(posedge clk);
    end
  endtask : result
  task automatic wrap_up();
    begin
      $display("comparisons %0d mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask : wrap_up
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    filter_zone_pkg::sample_s r;
    rst = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h00;
    wdata = 16'h0000;
    // median code 3 with window code 3 is never programmed
    rows = '{'{5'h10, 3'h0, 1, 12'h100, 12'h100},
      '{5'h14, 3'h1, 4, 12'h100, 12'h10e},
      '{5'h18, 3'h4, 8, 12'h100, 12'h146},
      '{5'h1c, 3'h5, 16, 12'h100, 12'h236},
      '{5'h11, 3'h6, 3, 12'h100, 12'h104},
      '{5'h12, 3'h2, 7, 12'h100, 12'h124},
      '{5'h13, 3'h3, 15, 12'h100, 12'h1c4},
      '{5'h15, 3'h0, 3, 12'h100, 12'h104},
      '{5'h16, 3'h1, 7, 12'h100, 12'h126},
      '{5'h1a, 3'h2, 7, 12'h100, 12'h124},
      '{5'h17, 3'h3, 15, 12'h100, 12'h1c6},
      '{5'h1b, 3'h4, 15, 12'h100, 12'h1d2},
      '{5'h00, 3'h5, 1, 12'hf00, 12'h300}};
    // aux at or above high, diode1 between, diode2 at or below low
    zr = '{'{3'h4, 12'h100, 1'b0}, '{3'h4, 12'h1ff, 1'b0}, '{3'h4, 12'h200, 1'b1},
      '{3'h5, 12'h100, 1'b0}, '{3'h5, 12'h101, 1'b1}, '{3'h5, 12'h1ff, 1'b1},
      '{3'h5, 12'h200, 1'b0}, '{3'h6, 12'h100, 1'b1}, '{3'h6, 12'h101, 1'b0},
      '{3'h0, 12'h050, 1'b1}};
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    check("irq idle", {15'h0, irq_n}, 16'h0001);
    check("valid idle", {15'h0, fvld}, 16'h0000);
    check("ready idle", {15'h0, rdy}, 16'h0001);
    check("filt idle", {1'b0, filt}, 16'h0000);
    @(posedge clk);
    rdchk("cfg reset", filter_zone_pkg::CFG_OFS, 16'h0010);
    rdchk("zone reset", filter_zone_pkg::ZONE_OFS, 16'h0000);
    rdchk("high reset", 8'h14, 16'h0fff);
    rdchk("unmapped", 8'h3c, 16'h0000);
    foreach (rows[i])
    begin
      bus(1'b1, filter_zone_pkg::CFG_OFS, {11'h0, rows[i].cfg});
      group(rows[i].ch, rows[i].n, rows[i].base);
      result(r);
      check("filt data", {4'h0, r.data}, {4'h0, rows[i].exp});
      check("filt ch", {13'h0, r.ch}, {13'h0, rows[i].ch});
      rdchk("result", filter_zone_pkg::RES_BASE + 8'(4 * rows[i].ch),
        {4'h0, rows[i].exp});
    end
    // input change mid-group, then back-to-back bypass beats
    bus(1'b1, filter_zone_pkg::CFG_OFS, 16'h0014);
    base_out = n_out;
    src.send(3'h4, 12'h7ff);
    src.send(3'h4, 12'h7ff);
    group(3'h5, 4, 12'h100);
    result(r);
    check("restart", {4'h0, r.data}, 16'h010e);
    bus(1'b1, filter_zone_pkg::CFG_OFS, 16'h0010);
    src.send(3'h6, 12'h123);
    src.send(3'h6, 12'h456);
    src.send(3'h6, 12'h789);
    src.idle();
    repeat (4) @(posedge clk);
    check("outputs", 16'(n_out - base_out), 16'h0004);
    rdchk("b2b result", filter_zone_pkg::RES_BASE + 8'h18, 16'h0789);
    bus(1'b1, filter_zone_pkg::ZONE_OFS, 16'h0247);
    for (int j = 0; j < 3; j++)
    begin
      bus(1'b1, filter_zone_pkg::THR_BASE + 8'(8 * j), 16'h0100);
      bus(1'b1, filter_zone_pkg::THR_BASE + 8'(8 * j + 4), 16'h0200);
    end
    foreach (zr[i])
    begin
      bus(1'b1, filter_zone_pkg::STAT_OFS, 16'h007f);
      src.send(zr[i].ch, zr[i].v);
      src.idle();
      repeat (3) @(posedge clk);
      @(negedge clk);
      check("irq", {15'h0, irq_n}, {15'h0, !zr[i].met});
      @(posedge clk);
      rdchk("flag", filter_zone_pkg::STAT_OFS, 16'(zr[i].met) << zr[i].ch);
    end
    bus(1'b1, filter_zone_pkg::ZONE_OFS, 16'h0246);
    bus(1'b1, filter_zone_pkg::STAT_OFS, 16'h007f);
    src.send(3'h4, 12'h150);
    src.idle();
    repeat (3) @(posedge clk);
    rdchk("zone off", filter_zone_pkg::STAT_OFS, 16'h0010);
    // reset in mid-group must drop the partial group
    bus(1'b1, filter_zone_pkg::CFG_OFS, 16'h0014);
    src.send(3'h1, 12'h0ff);
    src.idle();
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    check("irq reset", {15'h0, irq_n}, 16'h0001);
    check("ready reset", {15'h0, rdy}, 16'h0001);
    @(posedge clk);
    rdchk("cfg again", filter_zone_pkg::CFG_OFS, 16'h0010);
    rdchk("result cleared", filter_zone_pkg::RES_BASE + 8'h04, 16'h0000);
    group(3'h1, 1, 12'h321);
    result(r);
    check("after reset", {4'h0, r.data}, 16'h0321);
    wrap_up();
  end
endmodule : tb_sample_preprocess_filter_zone
`default_nettype wire
